// ### inc/aiob_pkg.sv
// package for the analog i/o bus port: offsets, fields, timing
package aiob_pkg;
	// register offsets within the 16-port block
	localparam logic [3:0] ADC_CTRL_OFS = 4'h0;
	localparam logic [3:0] ADC_LOW_OFS = 4'h0;
	localparam logic [3:0] ADC_HIGH_OFS = 4'h1;
	localparam logic [3:0] ADC_STAT_OFS = 4'h4;
	localparam logic [3:0] DAC_A_LOW_OFS = 4'h8;
	localparam logic [3:0] DAC_A_HIGH_OFS = 4'h9;
	localparam logic [3:0] DAC_B_LOW_OFS = 4'hA;
	localparam logic [3:0] DAC_B_HIGH_OFS = 4'hB;
	// block size and base decode
	localparam int PORT_COUNT = 16;
	localparam int BASE_W = 6;
	// control byte fields
	localparam int CTRL_DIFF_BIT = 4;
	localparam int CTRL_BIP_BIT = 3;
	localparam int CTRL_CH_LSB = 0;
	localparam int CTRL_CH_W = 3;
	// status byte busy position
	localparam int STAT_BUSY_BIT = 7;
	// reset values
	localparam logic [11:0] DAC_RST = 12'h000;
	localparam logic [11:0] RESULT_RST = 12'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	// conversion time: 10 us at 50 MHz core clock, period 20 ns
	localparam int CONV_TIME_NS = 10000;
	localparam int CLK_PERIOD_NS = 20;
	localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam logic [9:0] CONV_LAST = 10'(CONV_CYCLES - 1);
	// adc front-end request carrier, bus request carrier and sequencer states
	typedef struct packed {
		logic diff;
		logic bipolar;
		logic [2:0] chan;
	} aiob_conv_cfg_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
		logic wr;
		logic rd;
	} aiob_bus_req_t;
	typedef enum logic [1:0] {
		AIOB_IDLE = 2'b00,
		AIOB_CONV = 2'b01,
		AIOB_DONE = 2'b11
	} aiob_state_t;
endpackage : aiob_pkg

// ### testbench/aiob_conv_model.sv
// converter front-end model: answers each start with one code
`timescale 1ns/100ps
module aiob_conv_model (
	input wire logic i_core_clk,
	input wire logic i_start,
	input wire logic [11:0] i_next,
	output logic [11:0] o_code
);
	int cnt = 600;
	initial begin
		o_code = 12'h000;
	end
	// code held through the conversion, toggled outside it so a stale
	// sample shows up as a wrong result
	always @(posedge i_core_clk) begin
		if (i_start) begin
			cnt <= 0;
			o_code <= i_next;
		end else if (cnt < 520) begin
			cnt <= cnt + 1;
		end else begin
			o_code <= ~o_code;
		end
	end
endmodule : aiob_conv_model

// ### testbench/aiob_port_bench.sv
// self-checking bench for the analog i/o bus port
`timescale 1ns/100ps
module aiob_port_bench;
	import aiob_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [9:0] i_bus_addr = 10'h000;
	logic i_bus_iow_n = 1'b1;
	logic i_bus_ior_n = 1'b1;
	logic [7:0] i_bus_data = 8'h00;
	logic [5:0] i_base_jumper = 6'h00;
	logic [11:0] adc_code;
	logic [11:0] next_code = 12'h000;
	logic [7:0] o_bus_data;
	logic o_bus_data_oe_n;
	logic o_conv_irq;
	logic o_conv_start;
	aiob_conv_cfg_t o_conv_cfg;
	logic [11:0] o_dac_a;
	logic [11:0] o_dac_b;
	int fail_count = 0;
	int checks = 0;
	int starts = 0;
	int irqs = 0;
	int exp_q[$];
	`define CHK(a, b) begin checks++; if ((a) !== (b)) begin \
fail_count++; $display("BAD %0t got %h exp %h", $time, a, b); end end
	always #10 i_core_clk = ~i_core_clk;
	aiob_port i_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_bus_addr(i_bus_addr), .i_bus_iow_n(i_bus_iow_n),
		.i_bus_ior_n(i_bus_ior_n), .i_bus_data(i_bus_data),
		.i_base_jumper(i_base_jumper), .i_adc_code(adc_code),
		.o_bus_data(o_bus_data), .o_bus_data_oe_n(o_bus_data_oe_n),
		.o_conv_irq(o_conv_irq), .o_conv_cfg(o_conv_cfg),
		.o_conv_start(o_conv_start), .o_dac_a(o_dac_a), .o_dac_b(o_dac_b));
	aiob_conv_model i_model (.i_core_clk(i_core_clk),
		.i_start(o_conv_start), .i_next(next_code), .o_code(adc_code));
	// pulse counters, since both pulses last a single cycle
	always @(posedge i_core_clk) begin
		if (o_conv_start) starts++;
		if (o_conv_irq) irqs++;
	end
	task automatic close_out();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	task automatic ticks(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : ticks
	// strobe held long enough to cross the two sync stages
	task automatic bus_wr(input logic [3:0] ofs, input logic [7:0] d,
		input logic [5:0] base);
		i_bus_addr = {base, ofs};
		i_bus_data = d;
		i_bus_iow_n = 1'b0;
		ticks(4);
		i_bus_iow_n = 1'b1;
		ticks(4);
	endtask : bus_wr
	// driver must be off between reads; four ticks let the release cross
	task automatic bus_rd(input logic [3:0] ofs, output logic [7:0] d);
		`CHK(o_bus_data_oe_n, 1'b1)
		i_bus_addr = {i_base_jumper, ofs};
		i_bus_ior_n = 1'b0;
		ticks(5);
		d = o_bus_data;
		`CHK(o_bus_data_oe_n, 1'b0)
		i_bus_ior_n = 1'b1;
		ticks(4);
	endtask : bus_rd
	task automatic wait_irq(input int n0);
		int k;
		k = 0;
		while (irqs == n0 && k < 500) begin
			ticks(1);
			k++;
		end
		if (irqs == n0) begin
			fail_count++;
			$display("BAD %0t no completion", $time);
			close_out();
		end
	endtask : wait_irq
	initial begin
		logic [7:0] d;
		logic [7:0] c;
		logic [7:0] lo;
		logic [11:0] v;
		int s0;
		void'($urandom(45483));
		i_base_jumper = 6'($urandom);
		ticks(4);
		`CHK(o_dac_a, 12'h000)
		`CHK(o_dac_b, 12'h000)
		i_rst = 1'b0;
		ticks(3);
		// low byte alone stages, foreign base ignored, nibble updates
		for (int ch = 0; ch < 2; ch++) begin
			v = 12'($urandom);
			d = 8'($urandom);
			bus_wr(ch ? DAC_B_LOW_OFS : DAC_A_LOW_OFS, v[7:0], i_base_jumper);
			`CHK(ch ? o_dac_b : o_dac_a, 12'h000)
			c = {d[7:4], v[11:8]};
			bus_wr(ch ? DAC_B_HIGH_OFS : DAC_A_HIGH_OFS, c, i_base_jumper + 1);
			`CHK(ch ? o_dac_b : o_dac_a, 12'h000)
			bus_wr(ch ? DAC_B_HIGH_OFS : DAC_A_HIGH_OFS, c, i_base_jumper);
			`CHK(ch ? o_dac_b : o_dac_a, v)
		end
		bus_rd(4'h2, d);
		`CHK(d, 8'h00)
		// mid-run reset must clear both held dac values
		i_rst = 1'b1;
		ticks(2);
		`CHK(o_dac_a, 12'h000)
		`CHK(o_dac_b, 12'h000)
		i_rst = 1'b0;
		ticks(3);
		$display("test dac done");
		// every mode and channel, random unused bits and codes
		for (int m = 0; m < 32; m++) begin
			v = 12'($urandom);
			next_code = m[0] ? ~v : v;
			c = {3'($urandom), m[4:0]};
			exp_q.push_back(m[3] ? int'(v ^ 12'h800) : int'(v));
			s0 = starts;
			// odd passes restart mid-conversion: only the later code lands
			if (m[0]) begin
				bus_wr(ADC_CTRL_OFS, c, i_base_jumper);
				ticks(1);
				next_code = v;
			end
			bus_wr(ADC_CTRL_OFS, c, i_base_jumper);
			// start pulse follows the write by one cycle
			ticks(1);
			`CHK(starts, s0 + (m[0] ? 2 : 1))
			`CHK(o_conv_cfg, aiob_conv_cfg_t'(c[4:0]))
			s0 = irqs;
			bus_rd(ADC_STAT_OFS, d);
			`CHK(d, 8'h80)
			wait_irq(s0);
			ticks(3);
			`CHK(irqs, s0 + 1)
			bus_rd(ADC_STAT_OFS, d);
			`CHK(d, 8'h00)
			bus_rd(ADC_LOW_OFS, lo);
			bus_rd(ADC_HIGH_OFS, d);
			v = 12'(exp_q.pop_front());
			`CHK({d, lo}, {4'h0, v})
		end
		$display("test adc done");
		close_out();
	end
endmodule : aiob_port_bench

// ### verilog/aiob_port.sv
// bus-side control of the analog i/o board: adc control and dac latches
`timescale 1ns/100ps
module aiob_port (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [9:0] i_bus_addr,
	input wire logic i_bus_iow_n,
	input wire logic i_bus_ior_n,
	input wire logic [7:0] i_bus_data,
	input wire logic [aiob_pkg::BASE_W-1:0] i_base_jumper,
	input wire logic [11:0] i_adc_code,
	output logic [7:0] o_bus_data,
	output logic o_bus_data_oe_n,
	output logic o_conv_irq,
	output aiob_pkg::aiob_conv_cfg_t o_conv_cfg,
	output logic o_conv_start,
	output logic [11:0] o_dac_a,
	output logic [11:0] o_dac_b
);
	import aiob_pkg::*;

	// pin synchronisers: strobes, address and data come off the bus pins
	logic [9:0] addr_s1_r, addr_s2_r;
	logic [7:0] data_s1_r, data_s2_r;
	logic [1:0] iow_s1_r, iow_s2_r;
	logic [1:0] ior_s1_r, ior_s2_r;
	logic [BASE_W-1:0] base_s1_r, base_s2_r;
	logic [11:0] code_s1_r, code_s2_r;
	logic iow_d_r, ior_d_r;

	// only the stage-two copies feed logic
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			addr_s1_r <= 10'h000;
			addr_s2_r <= 10'h000;
			data_s1_r <= 8'h00;
			data_s2_r <= 8'h00;
			iow_s1_r <= 2'h3;
			iow_s2_r <= 2'h3;
			ior_s1_r <= 2'h3;
			ior_s2_r <= 2'h3;
			base_s1_r <= '0;
			base_s2_r <= '0;
			code_s1_r <= 12'h000;
			code_s2_r <= 12'h000;
		end else begin
			addr_s1_r <= i_bus_addr;
			addr_s2_r <= addr_s1_r;
			data_s1_r <= i_bus_data;
			data_s2_r <= data_s1_r;
			iow_s1_r <= {iow_s1_r[0], i_bus_iow_n};
			iow_s2_r <= iow_s1_r;
			ior_s1_r <= {ior_s1_r[0], i_bus_ior_n};
			ior_s2_r <= ior_s1_r;
			base_s1_r <= i_base_jumper;
			base_s2_r <= base_s1_r;
			code_s1_r <= i_adc_code;
			code_s2_r <= code_s1_r;
		end
	end

	// strobe levels after three flops, one more than address and data; the edge is taken off stage two
	logic iow_lvl_n, ior_lvl_n;
	assign iow_lvl_n = iow_s2_r[1];
	assign ior_lvl_n = ior_s2_r[1];

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			iow_d_r <= 1'b1;
			ior_d_r <= 1'b1;
		end else begin
			iow_d_r <= iow_lvl_n;
			ior_d_r <= ior_lvl_n;
		end
	end

	// base compare: upper address bits against the jumper field
	function automatic logic hits_block(input logic [9:0] a,
		input logic [BASE_W-1:0] b);
		hits_block = (a[9:4] == b);
	endfunction : hits_block

	logic sel, wr_pulse, rd_level;
	logic [3:0] ofs;
	assign sel = hits_block(addr_s2_r, base_s2_r);
	assign ofs = addr_s2_r[3:0];
	// a write acts once, on the rising edge of the write strobe
	assign wr_pulse = sel && !iow_d_r && iow_lvl_n;
	assign rd_level = sel && !ior_lvl_n;

	// conversion sequencer
	aiob_state_t state_r;
	logic [9:0] conv_cnt_r;
	logic [11:0] result_r;
	logic busy;
	logic conv_wr;
	assign conv_wr = wr_pulse && (ofs == ADC_CTRL_OFS);
	assign busy = (state_r == AIOB_CONV);

	// a new control write restarts even mid-conversion: back to back ok
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state_r <= AIOB_IDLE;
			conv_cnt_r <= 10'h000;
		end else begin
			case (state_r)
				AIOB_IDLE: begin
					if (conv_wr) begin
						state_r <= AIOB_CONV;
						conv_cnt_r <= 10'h000;
					end
				end
				AIOB_CONV: begin
					if (conv_wr) begin
						conv_cnt_r <= 10'h000;
					end else if (conv_cnt_r == CONV_LAST) begin
						state_r <= AIOB_DONE;
					end else begin
						conv_cnt_r <= conv_cnt_r + 10'h001;
					end
				end
				AIOB_DONE: begin
					state_r <= conv_wr ? AIOB_CONV : AIOB_IDLE;
					conv_cnt_r <= 10'h000;
				end
				default: state_r <= AIOB_IDLE;
			endcase
		end
	end

	// setup latch: upper three bits of the byte are dropped
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_conv_cfg <= '0;
		end else if (conv_wr) begin
			o_conv_cfg.diff <= data_s2_r[CTRL_DIFF_BIT];
			o_conv_cfg.bipolar <= data_s2_r[CTRL_BIP_BIT];
			o_conv_cfg.chan <= data_s2_r[CTRL_CH_LSB +: CTRL_CH_W];
		end
	end

	// start pulse to the converter, one cycle after the write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_conv_start <= 1'b0;
		end else begin
			o_conv_start <= conv_wr;
		end
	end

	// result latched on completion; converter gives offset code in
	// bipolar, so the msb is flipped to two's complement here
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			result_r <= RESULT_RST;
		end else if (state_r == AIOB_CONV && !conv_wr &&
			conv_cnt_r == CONV_LAST) begin
			result_r <= o_conv_cfg.bipolar ?
				{~code_s2_r[11], code_s2_r[10:0]} : code_s2_r;
		end
	end

	// completion request one cycle after the result is stored
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_conv_irq <= 1'b0;
		end else begin
			o_conv_irq <= (state_r == AIOB_DONE);
		end
	end

	// read mux; unused bits read zero
	logic [7:0] rd_nxt;
	always_comb begin
		rd_nxt = BYTE_RST;
		if (ofs == ADC_LOW_OFS) begin
			rd_nxt = result_r[7:0];
		end else if (ofs == ADC_HIGH_OFS) begin
			rd_nxt = {4'h0, result_r[11:8]};
		end else if (ofs == ADC_STAT_OFS) begin
			rd_nxt[STAT_BUSY_BIT] = busy;
		end
	end

	// read data held from flip-flops; driver enabled during read
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_bus_data <= BYTE_RST;
			o_bus_data_oe_n <= 1'b1;
		end else begin
			o_bus_data <= rd_nxt;
			o_bus_data_oe_n <= !rd_level;
		end
	end

	// dac low bytes are staged until the nibble write
	logic [7:0] dac_a_low_r, dac_b_low_r;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dac_a_low_r <= BYTE_RST;
			dac_b_low_r <= BYTE_RST;
		end else if (wr_pulse) begin
			if (ofs == DAC_A_LOW_OFS) begin
				dac_a_low_r <= data_s2_r;
			end else if (ofs == DAC_B_LOW_OFS) begin
				dac_b_low_r <= data_s2_r;
			end
		end
	end

	// outputs move only on the nibble write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_dac_a <= DAC_RST;
			o_dac_b <= DAC_RST;
		end else if (wr_pulse) begin
			if (ofs == DAC_A_HIGH_OFS) begin
				o_dac_a <= {data_s2_r[3:0], dac_a_low_r};
			end else if (ofs == DAC_B_HIGH_OFS) begin
				o_dac_b <= {data_s2_r[3:0], dac_b_low_r};
			end
		end
	end

	// assertions
	a_start_sets_busy: assert property (@(posedge i_core_clk)
		disable iff (i_rst) conv_wr |=> busy)
		else $error("busy not set after control write");
	a_cfg_latched: assert property (@(posedge i_core_clk)
		disable iff (i_rst) conv_wr |=>
		o_conv_cfg.chan == $past(data_s2_r[2:0]) &&
		o_conv_cfg.diff == $past(data_s2_r[4]))
		else $error("control byte not latched");
	a_busy_clears_done: assert property (@(posedge i_core_clk)
		disable iff (i_rst)
		(busy && conv_cnt_r == CONV_LAST && !conv_wr) |=> !busy)
		else $error("busy stuck after conversion");
	a_irq_after_done: assert property (@(posedge i_core_clk)
		disable iff (i_rst) state_r == AIOB_DONE |=> o_conv_irq)
		else $error("no completion request");
	a_irq_only_done: assert property (@(posedge i_core_clk)
		disable iff (i_rst) o_conv_irq |-> $past(state_r) == AIOB_DONE)
		else $error("spurious completion request");
	a_low_read: assert property (@(posedge i_core_clk)
		disable iff (i_rst) (ofs == ADC_LOW_OFS) |=>
		o_bus_data == $past(result_r[7:0]))
		else $error("low byte read wrong");
	a_high_read: assert property (@(posedge i_core_clk)
		disable iff (i_rst) (ofs == ADC_HIGH_OFS) |=>
		o_bus_data[7:4] == 4'h0)
		else $error("high read upper bits not zero");
	a_dac_a_hold: assert property (@(posedge i_core_clk)
		disable iff (i_rst) !(wr_pulse && ofs == DAC_A_HIGH_OFS) |=>
		$stable(o_dac_a))
		else $error("dac a moved without nibble write");
	a_dac_b_load: assert property (@(posedge i_core_clk)
		disable iff (i_rst) (wr_pulse && ofs == DAC_B_HIGH_OFS) |=>
		o_dac_b == {$past(data_s2_r[3:0]), $past(dac_b_low_r)})
		else $error("dac b load wrong");
	a_conv_length: assert property (@(posedge i_core_clk)
		disable iff (i_rst) $rose(busy) |-> busy [*8])
		else $error("conversion ended early");
endmodule : aiob_port
